// >>> hw/status_ind_pkg.sv
// Package with timing constants and display states for the status indicator controller
package status_ind_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ = 40000000;
  // Display blanking time in seconds
  localparam int unsigned BLANK_TIME_S = 60;
  // Blanking count in cycles, derived from time and clock rate
  localparam longint unsigned BLANK_CYCLES = longint'(BLANK_TIME_S) * longint'(CLK_HZ);
  // Blink half period in milliseconds
  localparam int unsigned BLINK_HALF_MS = 250;
  // Blink half period in cycles
  localparam longint unsigned BLINK_CYCLES = longint'(BLINK_HALF_MS) * longint'(CLK_HZ) / 1000;
  // Counter widths
  localparam int unsigned BLANK_W = 32;
  localparam int unsigned BLINK_W = 24;
  localparam int unsigned PAGE_W = 4;
  // Reset values
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
  // Display modes
  typedef enum logic [1:0] {disp_off, disp_summary, disp_detail} disp_state_type;
endpackage

// >>> hw/status_indicator_controller.sv
// Status LED and display paging controller for a safety scanner
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Green ON when any output is ON
// - Red OFF steady on field interruption
// - Red OFF blinks on error
// - Yellow blinks while restart interlock triggered
// - Yellow steady while restart delay runs
// - Yellow steady when warning field interrupted
// - Network LED green while link up and no traffic
// - Network LED blinks yellow on traffic
// - During start-up OFF lit, ON dark
// - After start-up show operational status
// - Blank display after 60 s idle
// - Brief press wakes blanked display
// - Press while active after start-up shows details
// - Mark multiple pages, step per press
// - Indicators diagnostic only, no safety feedback
module status_indicator_controller
  import status_ind_pkg::*;
#(
  parameter logic [BLANK_W-1:0] BLANK_LIMIT = BLANK_W'(BLANK_CYCLES),
  parameter logic [BLINK_W-1:0] BLINK_LIMIT = BLINK_W'(BLINK_CYCLES)
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic any_output_on_i,
  input wire logic field_off_i,
  input wire logic error_off_i,
  input wire logic manual_reset_cfg_i,
  input wire logic interlock_i,
  input wire logic auto_restart_cfg_i,
  input wire logic restart_delay_i,
  input wire logic warning_field_i,
  input wire logic link_up_i,
  input wire logic traffic_i,
  input wire logic startup_done_i,
  input wire logic notify_i,
  input wire logic button_i,
  input wire logic [PAGE_W-1:0] page_count_i,
  output logic led_on_green_o,
  output logic led_off_red_o,
  output logic led_warn_yellow_o,
  output logic led_net_green_o,
  output logic led_net_yellow_o,
  output logic display_en_o,
  output logic detail_o,
  output logic more_pages_o,
  output logic [PAGE_W-1:0] page_o
);

  // Blink divider and phase
  logic [BLINK_W-1:0] blink_cnt;
  logic blink;
  // Button edge detection and press pulse
  logic button_q;
  logic press;
  // Previous event levels for timer restart
  logic field_q;
  logic notify_q;
  // Blanking timer
  logic [BLANK_W-1:0] blank_cnt;
  logic idle;
  // Display state
  disp_state_type state;

  // Press is a rising edge of the button; inputs are synchronous already
  assign press = button_i && !button_q;
  // Display may blank only when nothing is interrupted or pending
  assign idle = !field_off_i && !warning_field_i && !error_off_i && !notify_i;

  // Free running blink phase shared by all flashing LEDs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else if (blink_cnt >= BLINK_LIMIT - 1'b1)
    begin
      blink_cnt <= '0;
      blink <= !blink;
    end
    else
    begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // Event history registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      button_q <= 1'b0;
      field_q <= 1'b0;
      notify_q <= 1'b0;
    end
    else
    begin
      button_q <= button_i;
      field_q <= field_off_i || warning_field_i;
      notify_q <= notify_i;
    end
  end

  // Blanking timer; counts only while idle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blank_cnt <= '0;
    end
    else if (press || ((field_off_i || warning_field_i) && !field_q) || (notify_i && !notify_q)
             || !idle || !startup_done_i)
    begin
      blank_cnt <= '0;
    end
    else if (blank_cnt != BLANK_LIMIT)
    begin
      blank_cnt <= blank_cnt + 1'b1;
    end
  end

  // Display state machine: off, summary, detail pages
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= disp_summary;
      page_o <= PAGE_RESET;
    end
    else
    begin
      case (state)
        disp_off:
        begin
          if (press || !idle)
          begin
            state <= disp_summary;
          end
        end
        disp_summary:
        begin
          // show details; checked before blanking, so a press beats it in the same cycle
          if (press && startup_done_i)
          begin
            state <= disp_detail;
            page_o <= PAGE_RESET;
          end
          // blank after idle time, never while something is pending
          else if (startup_done_i && idle && blank_cnt == BLANK_LIMIT)
          begin
            state <= disp_off;
          end
        end
        disp_detail:
        begin
          // step to next page, wrap to summary after last
          if (press)
          begin
            if (page_o + 1'b1 >= page_count_i)
            begin
              state <= disp_summary;
              page_o <= PAGE_RESET;
            end
            else
            begin
              page_o <= page_o + 1'b1;
            end
          end
          // blank from the detail view too, only while idle
          else if (idle && blank_cnt == BLANK_LIMIT)
          begin
            state <= disp_off;
            page_o <= PAGE_RESET;
          end
        end
        default:
        begin
          state <= disp_summary;
        end
      endcase
    end
  end

  // Display outputs registered from the state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      display_en_o <= 1'b0;
      detail_o <= 1'b0;
      more_pages_o <= 1'b0;
    end
    else
    begin
      display_en_o <= (state != disp_off);
      detail_o <= (state == disp_detail);
      more_pages_o <= (state == disp_detail) && (page_count_i > 4'h1);
    end
  end

  // Status LEDs; outputs only, nothing here feeds back into safety logic
  // diagnostic only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      led_on_green_o <= 1'b0;
      led_off_red_o <= 1'b1;
      led_warn_yellow_o <= 1'b0;
      led_net_green_o <= 1'b0;
      led_net_yellow_o <= 1'b0;
    end
    else if (!startup_done_i)
    begin
      led_on_green_o <= 1'b0;
      led_off_red_o <= 1'b1;
      led_warn_yellow_o <= 1'b0;
      led_net_green_o <= 1'b0;
      led_net_yellow_o <= 1'b0;
    end
    else
    begin
      led_on_green_o <= any_output_on_i;
      // error blinks, taking precedence over steady red
      if (error_off_i)
      begin
        led_off_red_o <= blink;
      end
      else
      begin
        led_off_red_o <= field_off_i;
      end
      // interlock blinks; steady causes win since they are more urgent
      if ((auto_restart_cfg_i && restart_delay_i) || warning_field_i)
      begin
        led_warn_yellow_o <= 1'b1;
      end
      else
      begin
        led_warn_yellow_o <= manual_reset_cfg_i && interlock_i && blink;
      end
      led_net_green_o <= link_up_i && !traffic_i;
      led_net_yellow_o <= traffic_i && blink;
    end
  end

endmodule // status_indicator_controller

`default_nettype wire

// >>> verification/operator_model.sv
// Operator who gives brief pushbutton presses
`timescale 1ns/1ps
`default_nettype none
module operator_model (
  input wire logic clk_i, rst_i, press_i,
  output logic button_o
);
  logic [1:0] hold; // Cycles left of the press
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) hold <= 2'h0;
    else if (press_i) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
  assign button_o = hold != 2'h0;
endmodule // operator_model
`default_nettype wire

// >>> verification/status_ind_props.sv
// Port checker for the status indicator controller
`timescale 1ns/1ps
`default_nettype none
module status_ind_props (
  input wire logic clk_i, rst_i, any_output_on_i, field_off_i, error_off_i,
  input wire logic warning_field_i, auto_restart_cfg_i, restart_delay_i,
  input wire logic link_up_i, traffic_i, startup_done_i, button_i,
  input wire logic led_on_green_o, led_off_red_o, led_warn_yellow_o,
  input wire logic led_net_green_o, display_en_o, detail_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire s = startup_done_i; // Start-up finished
  property p_on; $past(s) |-> led_on_green_o == $past(any_output_on_i); endproperty
  a_on: assert property (p_on) else $error("bad green");
  property p_red; $past(s && field_off_i && !error_off_i) |-> led_off_red_o; endproperty
  a_red: assert property (p_red) else $error("bad red");
  // Eight still samples cannot happen with a short blink period
  property p_rblink; not (s && error_off_i && $stable(led_off_red_o))[*8]; endproperty
  a_rblink: assert property (p_rblink) else $error("red not blinking");
  property p_yel;
    $past(s && (warning_field_i || auto_restart_cfg_i && restart_delay_i)) |-> led_warn_yellow_o;
  endproperty
  a_yel: assert property (p_yel) else $error("bad yellow");
  property p_net; $past(s && link_up_i && !traffic_i) |-> led_net_green_o; endproperty
  a_net: assert property (p_net) else $error("bad net green");
  property p_boot; $past(!s) |-> led_off_red_o && !led_on_green_o; endproperty
  a_boot: assert property (p_boot) else $error("bad start-up lamps");
  property p_wake; $rose(button_i) && !display_en_o |-> ##2 display_en_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  // The state a press meets shows on the outputs one cycle after the press
  property p_detail;
    $rose(button_i) && s ##1 display_en_o && !detail_o |-> ##1 detail_o;
  endproperty
  a_detail: assert property (p_detail) else $error("no detail");
endmodule // status_ind_props
bind status_indicator_controller status_ind_props u_props (.*);
`default_nettype wire

// >>> verification/tb_status_indicator_controller.sv
// Random and directed bench for the status indicator controller
`timescale 1ns/1ps
`default_nettype none
module tb_status_indicator_controller;
  logic clk_i = 0, rst_i = 1, sd = 0, press = 0, btn, g, r, y, ng, ny, de, dt, mp;
  logic [10:0] st = 11'h0; // Status inputs driven together
  logic [3:0] pc = 4'h3, pg;
  wire [2:0] bl = {ny, y, r}; // Blinking lamps
  int bad_count = 0, total_checks = 0, k;
  always #12.5 clk_i = ~clk_i;
  operator_model op (.clk_i(clk_i), .rst_i(rst_i), .press_i(press), .button_o(btn));
  status_indicator_controller #(.BLANK_LIMIT(32'h32), .BLINK_LIMIT(24'h4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .any_output_on_i(st[10]), .field_off_i(st[9]),
    .error_off_i(st[8]), .manual_reset_cfg_i(st[7]), .interlock_i(st[6]),
    .auto_restart_cfg_i(st[5]), .restart_delay_i(st[4]), .warning_field_i(st[3]),
    .link_up_i(st[2]), .traffic_i(st[1]), .notify_i(st[0]), .startup_done_i(sd),
    .button_i(btn), .page_count_i(pc), .led_on_green_o(g), .led_off_red_o(r),
    .led_warn_yellow_o(y), .led_net_green_o(ng), .led_net_yellow_o(ny),
    .display_en_o(de), .detail_o(dt), .more_pages_o(mp), .page_o(pg));
  function automatic logic [5:0] greens(input logic [10:0] s, input logic d);
    return {4'h0, d & s[10], d & s[2] & ~s[1]};
  endfunction
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One brief press, then time for the display to settle
  task automatic push;
    @(posedge clk_i);
    press <= 1'b1;
    @(posedge clk_i);
    press <= 1'b0;
    tick(6);
  endtask
  initial
  begin
    void'($urandom(2480));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (300)
    begin
      @(posedge clk_i);
      st <= 11'($urandom);
      sd <= $urandom % 4 != 0;
      tick(1);
      chk({4'h0, g, ng}, greens(st, sd));
      if (!st[8] && (st[9] || !sd)) chk(6'(r), 6'h1);
      if (sd && (st[3] || st[5] && st[4])) chk(6'(y), 6'h1);
    end
    $display("random test done");
    // Error, interlock and traffic must each blink their lamp
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      st <= i == 0 ? 11'h100 : i == 1 ? 11'h0c0 : 11'h006;
      sd <= 1'b1;
      k = 0;
      repeat (24)
      begin
        tick(1);
        k += bl[i];
      end
      chk(6'(k > 4 && k < 20), 6'h1);
    end
    $display("blink test done");
    @(posedge clk_i);
    st <= 11'h008;
    @(posedge clk_i);
    st <= 11'h0;
    tick(1);
    for (k = 0; k < 200 && de !== 1'b0; k++)
      tick(1);
    chk(6'(k > 44 && k < 200), 6'h1);
    if (k == 200)
      print_verdict();
    push;
    chk(6'(de), 6'h1);
    push;
    chk({dt, mp, pg}, 6'h30);
    push;
    chk({dt, mp, pg}, 6'h31);
    push;
    chk({dt, mp, pg}, 6'h32);
    // Press on the last page returns to the summary
    push;
    chk({dt, mp, pg}, 6'h00);
    // A single page shows no multi-page marker
    @(posedge clk_i);
    pc <= 4'h1;
    push;
    chk({dt, mp, pg}, 6'h20);
    $display("display test done");
    print_verdict();
  end
endmodule // tb_status_indicator_controller
`default_nettype wire
